// [shared/sdil_map.svh]
`ifndef SDIL_MAP_SVH
`define SDIL_MAP_SVH

// Input channels per gated half
`define SDIL_HALF_WIDTH 16
// Number of gated halves
`define SDIL_HALF_COUNT 2
// Channels per host read byte
`define SDIL_BYTE_WIDTH 8
// Host port offsets of the four input bytes
`define SDIL_OFS_BYTE0 2'h0
`define SDIL_OFS_BYTE1 2'h1
`define SDIL_OFS_BYTE2 2'h2
`define SDIL_OFS_BYTE3 2'h3
// Reset values
`define SDIL_RST_GATE 1'h1
`define SDIL_RST_HOLD 16'h0000
`define SDIL_RST_BYTE 8'h00

`endif

// [shared/sdil_pkg.sv]
package sdil_pkg;

    typedef enum logic [0:0] {
        SDIL_TRANSPARENT = 1'b0,
        SDIL_HELD = 1'b1
    } sdil_mode_t;

endpackage

// [hw/sdil_half.sv]
`timescale 1ns/10ps
`include "sdil_map.svh"

// ****************************************
// One gated half of the input port
// ****************************************
module sdil_half
    import sdil_pkg::*;
#(
    parameter int WIDTH = `SDIL_HALF_WIDTH
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // Pins, already synchronised
    input wire logic [WIDTH-1:0] pins_sync_i,
    input wire logic gate_sync_i,
    // Effective view
    output logic [WIDTH-1:0] view_o,
    output logic held_o
);

    if (WIDTH < 1) begin : g_bad_width
        $error("sdil_half: WIDTH must be at least 1");
    end

    logic gate_prev_q;
    logic gate_prev_d;
    logic [WIDTH-1:0] hold_q;
    logic [WIDTH-1:0] hold_d;
    sdil_mode_t mode_q;
    sdil_mode_t mode_d;
    logic fall;

    // Edge taken from synchronised copy only, never the raw pin
    assign fall = gate_prev_q && !gate_sync_i; // R8

    always_comb begin
        gate_prev_d = gate_sync_i;
        hold_d = hold_q;
        mode_d = mode_q;
        case (mode_q)
            SDIL_TRANSPARENT: begin
                if (fall) begin
                    hold_d = pins_sync_i; // R2
                    mode_d = SDIL_HELD;
                end
            end
            SDIL_HELD: begin
                if (gate_sync_i) begin
                    mode_d = SDIL_TRANSPARENT; // R1
                end
            end
            default: begin
                mode_d = SDIL_TRANSPARENT;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            gate_prev_q <= `SDIL_RST_GATE;
            hold_q <= WIDTH'(`SDIL_RST_HOLD);
            mode_q <= SDIL_TRANSPARENT;
        end else begin
            gate_prev_q <= gate_prev_d;
            hold_q <= hold_d;
            mode_q <= mode_d;
        end
    end

    // Held value while mode_q is SDIL_HELD, live value otherwise
    assign view_o = (mode_q == SDIL_HELD) ? hold_q : pins_sync_i; // R1 R3
    assign held_o = (mode_q == SDIL_HELD);

    a_capture_on_fall: assert property (@(posedge clk_sys_i) disable iff (reset_i) // R2
        fall && mode_q == SDIL_TRANSPARENT |=> held_o && hold_q == $past(pins_sync_i))
        else $error("half did not capture pins on gate fall");

    a_hold_while_low: assert property (@(posedge clk_sys_i) disable iff (reset_i) // R3
        held_o && !gate_sync_i |=> held_o && $stable(hold_q))
        else $error("held value changed while gate low");

    a_live_when_high: assert property (@(posedge clk_sys_i) disable iff (reset_i) // R1
        gate_prev_q && gate_sync_i |-> view_o == pins_sync_i)
        else $error("view not transparent while gate high");

    a_release_on_rise: assert property (@(posedge clk_sys_i) disable iff (reset_i) // R1
        held_o && gate_sync_i |=> !held_o)
        else $error("half stayed held after gate rose");

endmodule

// [hw/sdil_top.sv]
`timescale 1ns/10ps
`include "sdil_map.svh"

// Behaviour
// R1: Gate high or open: reads show live pins
// R2: Gate falling edge captures sixteen pins of half
// R3: Gate held low: reads show captured value
// R4: First gate serves channels 0 to 15
// R5: Second gate serves channels 16 to 31
// R6: Offset selects eight channels, eight times offset
// R7: Host reads one of four byte offsets
// R8: Gates synchronised, open gate counts as high
module sdil_top
    import sdil_pkg::*;
#(
    parameter int HALF_WIDTH = `SDIL_HALF_WIDTH
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // Input pins of both connectors
    input wire logic [HALF_WIDTH-1:0] lower_input_connector_i,
    input wire logic [HALF_WIDTH-1:0] upper_input_connector_i,
    // Gate lines, pulled high when open
    input wire logic gate0_i,
    input wire logic gate1_i,
    // Host read port
    input wire logic rd_en_i,
    input wire logic [1:0] rd_addr_i,
    output logic [`SDIL_BYTE_WIDTH-1:0] rd_data_o,
    output logic rd_valid_o,
    // Status
    output logic [`SDIL_HALF_COUNT-1:0] held_o
);

    localparam int TOTAL = HALF_WIDTH * `SDIL_HALF_COUNT;
    localparam int BW = `SDIL_BYTE_WIDTH;

    // ****************************************
    // Elaboration checks
    // ****************************************
    // The byte map has four fixed offsets; a wider half would leave
    // channels that no read can reach, a narrower one offsets with no channels
    if (HALF_WIDTH != `SDIL_HALF_WIDTH) begin : g_bad_half_width
        $error("sdil_top: four byte offsets need 16 channels per half");
    end
    if (HALF_WIDTH % BW != 0) begin : g_bad_byte_split
        $error("sdil_top: a half must split into whole bytes");
    end

    // ****************************************
    // Synchronisers
    // ****************************************
    logic [TOTAL+1:0] raw;
    logic [TOTAL+1:0] s1_q;
    logic [TOTAL+1:0] s1_d;
    logic [TOTAL+1:0] s2_q;
    logic [TOTAL+1:0] s2_d;

    // Pads with no driver must read high on the board pull-up; logic cannot see open
    // Pins reach the halves two edges after they change; a gate fall shows on
    // held_o at the third edge. A strobe low for less than one clock may be lost.
    assign raw = {gate1_i, gate0_i, upper_input_connector_i, lower_input_connector_i};

    always_comb begin
        s1_d = raw;
        s2_d = s1_q;
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            // Gates start high so no false fall follows reset
            s1_q <= {{`SDIL_HALF_COUNT{`SDIL_RST_GATE}}, {TOTAL{1'b0}}}; // R8
            s2_q <= {{`SDIL_HALF_COUNT{`SDIL_RST_GATE}}, {TOTAL{1'b0}}};
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d; // R8
        end
    end

    // ****************************************
    // Two independent halves
    // ****************************************
    logic [TOTAL-1:0] view;

    genvar h;
    generate
        for (h = 0; h < `SDIL_HALF_COUNT; h++) begin : g_half
            sdil_half #(
                .WIDTH(HALF_WIDTH)
            ) u_half (
                .clk_sys_i(clk_sys_i),
                .reset_i(reset_i),
                .pins_sync_i(s2_q[h*HALF_WIDTH +: HALF_WIDTH]), // R4 R5
                .gate_sync_i(s2_q[TOTAL+h]), // R4 R5
                .view_o(view[h*HALF_WIDTH +: HALF_WIDTH]),
                .held_o(held_o[h])
            );
        end
    endgenerate

    // ****************************************
    // Host read port
    // ****************************************
    // Offsets decode here for the port only; the checks below slice view by offset on their own
    function automatic logic [BW-1:0] pick_byte(input logic [TOTAL-1:0] v,
                                                input logic [1:0] a);
        logic [BW-1:0] r;
        r = `SDIL_RST_BYTE;
        if (a == `SDIL_OFS_BYTE0) begin
            r = v[0 +: BW];
        end else if (a == `SDIL_OFS_BYTE1) begin
            r = v[BW +: BW];
        end else if (a == `SDIL_OFS_BYTE2) begin
            r = v[2*BW +: BW];
        end else if (a == `SDIL_OFS_BYTE3) begin
            r = v[3*BW +: BW];
        end
        return r;
    endfunction

    logic [BW-1:0] data_q;
    logic [BW-1:0] data_d;
    logic valid_q;
    logic valid_d;

    // View is taken in the cycle of the request; the byte answers one edge later
    always_comb begin
        data_d = data_q;
        valid_d = rd_en_i; // R7
        if (rd_en_i) begin
            data_d = pick_byte(view, rd_addr_i); // R6
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            data_q <= `SDIL_RST_BYTE;
            valid_q <= 1'b0;
        end else begin
            data_q <= data_d;
            valid_q <= valid_d;
        end
    end

    assign rd_data_o = data_q;
    assign rd_valid_o = valid_q;

    // ****************************************
    // Checks on the read port
    // ****************************************
    a_read_byte_map: assert property (@(posedge clk_sys_i) disable iff (reset_i) // R6
        rd_en_i |=> rd_valid_o && rd_data_o == $past(view[rd_addr_i*BW +: BW]))
        else $error("read byte does not match selected channels");

    a_valid_one_cycle: assert property (@(posedge clk_sys_i) disable iff (reset_i) // R7
        !rd_en_i |=> !rd_valid_o)
        else $error("read valid without a read");

    a_valid_needs_read: assert property (@(posedge clk_sys_i) disable iff (reset_i) // R7
        rd_valid_o |-> $past(rd_en_i))
        else $error("read valid not preceded by a read");

    // Read data stands until the next read, so the host may sample it late
    a_data_holds_idle: assert property (@(posedge clk_sys_i) disable iff (reset_i) // R6
        !rd_en_i |=> $stable(rd_data_o))
        else $error("read data changed without a read");

    // One check per offset, so two swapped bytes cannot hide
    for (genvar o = 0; o < TOTAL / BW; o++) begin : g_byte_check
        a_offset_byte: assert property (@(posedge clk_sys_i) disable iff (reset_i) // R6
            rd_en_i && rd_addr_i == 2'(o) |=> rd_data_o == $past(view[o*BW +: BW]))
            else $error("offset returned the wrong eight channels");
    end

    // ****************************************
    // Checks per half, from the pins inward
    // ****************************************
    a_halves_apart: assert property (@(posedge clk_sys_i) disable iff (reset_i) // R4
        !s2_q[TOTAL] && s2_q[TOTAL+1] ##1 s2_q[TOTAL+1] |-> !held_o[1])
        else $error("upper half held by lower gate");

    a_sync_depth: assert property (@(posedge clk_sys_i) disable iff (reset_i) // R8
        ##2 s2_q == $past(raw, 2))
        else $error("synchroniser is not two stages");

    for (genvar c = 0; c < `SDIL_HALF_COUNT; c++) begin : g_half_check
        localparam int LO = c * HALF_WIDTH;
        localparam int GATE = TOTAL + c;

        // Two synchroniser stages and the mode register: held on the third edge
        a_fall_to_held: assert property (@(posedge clk_sys_i) disable iff (reset_i) // R2
            $fell(raw[GATE]) |-> ##3 held_o[c])
            else $error("half not held three edges after gate fall");

        a_rise_to_live: assert property (@(posedge clk_sys_i) disable iff (reset_i) // R1
            $rose(raw[GATE]) |-> ##3 !held_o[c])
            else $error("half still held three edges after gate rise");

        a_capture_pins: assert property (@(posedge clk_sys_i) disable iff (reset_i) // R2
            $fell(s2_q[GATE]) |=> view[LO +: HALF_WIDTH] == $past(s2_q[LO +: HALF_WIDTH]))
            else $error("captured value is not the pins at the gate fall");

        a_low_keeps_held: assert property (@(posedge clk_sys_i) disable iff (reset_i) // R3
            !s2_q[GATE] ##1 !s2_q[GATE] |-> held_o[c])
            else $error("half not held while gate low");

        a_held_view_frozen: assert property (@(posedge clk_sys_i) disable iff (reset_i) // R3
            held_o[c] && $past(held_o[c]) |-> $stable(view[LO +: HALF_WIDTH]))
            else $error("held view moved while gate low");

        a_high_shows_live: assert property (@(posedge clk_sys_i) disable iff (reset_i) // R1
            s2_q[GATE] ##1 s2_q[GATE] |-> view[LO +: HALF_WIDTH] == s2_q[LO +: HALF_WIDTH])
            else $error("view not live while gate high");

        // Ties each connector to its own channels; the reset preset is skipped
        a_pins_reach_view: assert property (@(posedge clk_sys_i) disable iff (reset_i) // R4 R5
            !held_o[c] && !$past(reset_i, 2)
                |-> view[LO +: HALF_WIDTH] == $past(raw[LO +: HALF_WIDTH], 2))
            else $error("connector pins not on their own channels");
    end

endmodule

// [sim/sdil_src.sv]
`timescale 1ns/10ps

// ****************************************
// External signal sources and strobe drivers
// ****************************************
module sdil_src (
    // Pins and strobe lines toward the port
    output logic [15:0] lower_o,
    output logic [15:0] upper_o,
    output logic [1:0] gate_o
);
    // An unconnected strobe line idles high through the board pull-up
    initial begin
        lower_o = 16'h0000;
        upper_o = 16'h0000;
        gate_o = 2'h3;
    end

    task automatic drive(input logic [15:0] lo, input logic [15:0] up);
        lower_o = lo;
        upper_o = up;
    endtask

    task automatic strobe(input int h, input logic lvl);
        gate_o[h] = lvl;
    endtask
endmodule

// [sim/tb.sv]
`timescale 1ns/10ps

// ****************************************
// Bench for the strobed input port
// ****************************************
module tb;
    logic clk_sys_i = 1'b0;
    logic reset_i = 1'b1;
    logic rd_en_i = 1'b0;
    logic [1:0] rd_addr_i = 2'h0;
    logic [7:0] rd_data_o;
    logic rd_valid_o;
    logic [1:0] held_o;
    logic [15:0] lower_w;
    logic [15:0] upper_w;
    logic [1:0] gate_w;
    int fail_count = 0;
    int tests_run = 0;

    always #4 clk_sys_i = ~clk_sys_i;

    sdil_src i_sdil_src (.lower_o(lower_w), .upper_o(upper_w), .gate_o(gate_w));

    sdil_top #(.HALF_WIDTH(16)) i_sdil_top (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .lower_input_connector_i(lower_w),
        .upper_input_connector_i(upper_w),
        .gate0_i(gate_w[0]),
        .gate1_i(gate_w[1]),
        .rd_en_i(rd_en_i),
        .rd_addr_i(rd_addr_i),
        .rd_data_o(rd_data_o),
        .rd_valid_o(rd_valid_o),
        .held_o(held_o)
    );

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    // One host read; valid stands for a single cycle, the data byte stays after it
    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        rd_en_i = 1'b1;
        rd_addr_i = a;
        cyc(1);
        rd_en_i = 1'b0;
        chk("rd_valid_o", 32'h1, {31'h0, rd_valid_o});
        chk("rd_data_o", {24'h0, e}, {24'h0, rd_data_o});
        cyc(1);
        chk("rd_valid_o", 32'h0, {31'h0, rd_valid_o});
        chk("rd_data_o", {24'h0, e}, {24'h0, rd_data_o});
    endtask

    task automatic rd4(input logic [31:0] e);
        for (int i = 0; i < 4; i++) begin
            rd(i[1:0], e[8*i+:8]);
        end
    endtask

    task automatic t_live();
        i_sdil_src.drive(16'hA55A, 16'h3CC3);
        cyc(3);
        chk("held_o", 32'h0, {30'h0, held_o});
        rd4(32'h3CC3A55A);
    endtask

    // Capture one half, move the pins, then release the strobe
    task automatic t_hold(input int h);
        logic [31:0] e;
        i_sdil_src.drive(16'h1234, 16'h5678);
        cyc(3);
        i_sdil_src.strobe(h, 1'b0);
        cyc(4);
        i_sdil_src.drive(16'hFEDC, 16'hBA98);
        cyc(3);
        e = (h == 0) ? 32'hBA981234 : 32'h5678FEDC;
        chk("held_o", 32'h1 << h, {30'h0, held_o});
        rd4(e);
        i_sdil_src.strobe(h, 1'b1);
        cyc(5);
        chk("held_o", 32'h0, {30'h0, held_o});
        rd4(32'hBA98FEDC);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        #100000;
        fail_count++;
        conclude();
    end

    initial begin
        repeat (6) @(posedge clk_sys_i);
        #1;
        reset_i = 1'b0;
        cyc(2);
        t_live();
        t_hold(0);
        t_hold(1);
        conclude();
    end
endmodule
